// file: src/drse_encoder.v
`include "drse_defs.vh"

//Function
//RULE_01 - status bytes offered on data register
//RULE_02 - bits 7:6 class 00 ok, 01 abnormal
//RULE_03 - class 10 invalid, 11 polling abort
//RULE_04 - bit 5 set after seek complete
//RULE_05 - fault after 80 steps without cylinder zero
//RULE_06 - fault when relative seek passes cylinder zero
//RULE_07 - unused bits always read zero
//RULE_08 - bit 2 reports current head
//RULE_09 - bits 1:0 report selected drive
//RULE_10 - overrun past last sector or no stop
//RULE_11 - crc mismatch in id or data field
//RULE_12 - late host or dma service flag
//RULE_13 - sector missing in three read cases
//RULE_14 - write protect during write or format
//RULE_15 - identifier or data mark lost
//RULE_16 - capture at termination, hold until read
module drse_encoder (
   input wire mclk_i,
   input wire reset_n_i,
   input wire cmd_start_i,
   input wire cmd_done_i,
   input wire [1:0] term_class_i,
   input wire cmd_invalid_i,
   input wire poll_abort_i,
   input wire is_seek_cmd_i,
   input wire is_recal_cmd_i,
   input wire is_rel_seek_cmd_i,
   input wire is_rw_data_cmd_i,
   input wire is_read_data_cmd_i,
   input wire is_read_id_cmd_i,
   input wire is_read_track_cmd_i,
   input wire is_write_cmd_i,
   input wire step_pulse_i,
   input wire step_outward_i,
   input wire [7:0] cylinder_i,
   input wire cylinder_zero_sense_i,
   input wire protect_tab_input_i,
   input wire index_pulse_input_i,
   input wire transfer_stop_i,
   input wire side_select_value_i,
   input wire [1:0] drive_number_i,
   input wire [7:0] sector_num_i,
   input wire sector_access_i,
   input wire id_crc_err_i,
   input wire data_crc_err_i,
   input wire service_late_i,
   input wire sector_not_found_i,
   input wire id_read_fail_i,
   input wire seq_fail_i,
   input wire id_mark_found_i,
   input wire data_mark_missing_i,
   input wire rd_strobe_i,
   output reg [7:0] result_data_o,
   output reg result_valid_o,
   output reg result_busy_o
);
   localparam ST_IDLE = 2'h0;
   localparam ST_EXEC = 2'h1;
   localparam ST_RES = 2'h2;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [6:0] step_cnt_q;
   reg [1:0] idx_cnt_q;
   reg stop_seen_q;
   reg [7:0] byte0_q;
   reg [7:0] byte1_q;
   reg [7:0] byte0_d;
   reg [7:0] byte1_d;
   reg rd_idx_q;
   reg [1:0] class_d;
   wire exec;
   wire clr;
   wire capture;
   wire first_rd;
   wire last_rd;
   wire f_pos;
   wire f_fault;
   wire f_over;
   wire f_crc;
   wire f_late;
   wire f_miss;
   wire f_wp;
   wire f_idl;
   wire recal_fail;
   wire rel_under;
   wire seek_end;
   wire past_end;
   wire no_stop;
   wire lost_id;
   wire set_fault;
   wire set_over;
   wire set_crc;
   wire set_late;
   wire set_miss;
   wire set_wp;
   wire set_idl;
   wire any_err;

   assign exec = (state_q == ST_EXEC);
   assign clr = cmd_start_i;
   // capture only while executing, so a stray done in idle or result is ignored
   assign capture = exec && cmd_done_i;
   assign first_rd = (state_q == ST_RES) && rd_strobe_i && !rd_idx_q;
   assign last_rd = (state_q == ST_RES) && rd_strobe_i && rd_idx_q;
   // the 80th step is the last chance for the cylinder zero sensor
   assign recal_fail = exec && is_recal_cmd_i && step_pulse_i && !cylinder_zero_sense_i &&
                       (step_cnt_q == `DRSE_RECAL_STEPS - 7'h01); // RULE_05
   assign rel_under = exec && is_rel_seek_cmd_i && step_pulse_i && step_outward_i &&
                      (cylinder_i == 8'h00); // RULE_06
   assign seek_end = capture && (is_seek_cmd_i || is_recal_cmd_i || is_rel_seek_cmd_i); // RULE_04
   assign past_end = exec && sector_access_i && (sector_num_i == `DRSE_LAST_SECTOR); // RULE_10
   assign no_stop = capture && is_rw_data_cmd_i && !stop_seen_q && !transfer_stop_i; // RULE_10
   assign lost_id = exec && index_pulse_input_i && !id_mark_found_i &&
                    (idx_cnt_q == `DRSE_INDEX_LIMIT - 2'h1); // RULE_15
   assign set_fault = recal_fail || rel_under;
   assign set_over = past_end || no_stop;
   assign set_crc = exec && (id_crc_err_i || data_crc_err_i);
   assign set_late = exec && service_late_i;
   assign set_miss = exec && ((is_read_data_cmd_i && sector_not_found_i) ||
                     (is_read_id_cmd_i && id_read_fail_i) || (is_read_track_cmd_i && seq_fail_i));
   assign set_wp = exec && is_write_cmd_i && protect_tab_input_i;
   assign set_idl = lost_id || (exec && data_mark_missing_i);
   // events of the terminating cycle count as much as the sticky ones
   assign any_err = f_fault || f_over || f_crc || f_late || f_miss || f_wp || f_idl ||
                    set_fault || set_over || set_crc || set_late || set_miss || set_wp || set_idl;

   drse_sticky u_pos (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .clr_i(clr),
      .set_i(seek_end),
      .flag_o(f_pos)
   ); // RULE_04
   drse_sticky u_fault (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .clr_i(clr),
      .set_i(set_fault),
      .flag_o(f_fault)
   ); // RULE_05 RULE_06
   drse_sticky u_over (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .clr_i(clr),
      .set_i(set_over),
      .flag_o(f_over)
   ); // RULE_10
   drse_sticky u_crc (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .clr_i(clr),
      .set_i(set_crc),
      .flag_o(f_crc)
   ); // RULE_11
   drse_sticky u_late (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .clr_i(clr),
      .set_i(set_late),
      .flag_o(f_late)
   ); // RULE_12
   drse_sticky u_miss (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .clr_i(clr),
      .set_i(set_miss),
      .flag_o(f_miss)
   ); // RULE_13
   drse_sticky u_wp (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .clr_i(clr),
      .set_i(set_wp),
      .flag_o(f_wp)
   ); // RULE_14
   drse_sticky u_idl (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .clr_i(clr),
      .set_i(set_idl),
      .flag_o(f_idl)
   ); // RULE_15

   // step pulses of a recalibrate, held at the limit so it cannot wrap
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         step_cnt_q <= 7'h00;
      end else if (cmd_start_i) begin
         step_cnt_q <= 7'h00;
      end else if (exec && is_recal_cmd_i && step_pulse_i && step_cnt_q != `DRSE_RECAL_STEPS) begin
         step_cnt_q <= step_cnt_q + 7'h01; // RULE_05
      end
   end

   // index passes since the last identifier mark
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idx_cnt_q <= 2'h0;
      end else if (cmd_start_i) begin
         idx_cnt_q <= 2'h0;
      end else if (exec && id_mark_found_i) begin
         idx_cnt_q <= 2'h0;
      end else if (exec && index_pulse_input_i && idx_cnt_q != `DRSE_INDEX_LIMIT) begin
         idx_cnt_q <= idx_cnt_q + 2'h1; // RULE_15
      end
   end

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stop_seen_q <= 1'b0;
      end else if (cmd_start_i) begin
         stop_seen_q <= 1'b0;
      end else if (exec && transfer_stop_i) begin
         stop_seen_q <= 1'b1; // RULE_10
      end
   end

   // invalid and polling take priority over the sequencer's own class
   always @* begin
      if (cmd_invalid_i) begin
         class_d = `DRSE_TC_INVALID; // RULE_03
      end else if (poll_abort_i) begin
         class_d = `DRSE_TC_POLLING; // RULE_03
      end else if (term_class_i == `DRSE_TC_NORMAL && any_err) begin
         class_d = `DRSE_TC_ABNORMAL; // RULE_02
      end else begin
         class_d = term_class_i; // RULE_02
      end
   end

   // both bytes built from the flags plus the terminating cycle's events
   always @* begin
      byte0_d = `DRSE_BYTE_RESET; // RULE_07
      byte0_d[`DRSE_S0_TC_HI:`DRSE_S0_TC_LO] = class_d; // RULE_02 RULE_03
      byte0_d[`DRSE_S0_POS_DONE] = f_pos || seek_end; // RULE_04
      byte0_d[`DRSE_S0_DRV_FAULT] = f_fault || set_fault; // RULE_05 RULE_06
      byte0_d[`DRSE_S0_HEAD] = side_select_value_i; // RULE_08
      byte0_d[`DRSE_S0_DRV_HI:`DRSE_S0_DRV_LO] = drive_number_i; // RULE_09
   end

   always @* begin
      byte1_d = `DRSE_BYTE_RESET; // RULE_07
      byte1_d[`DRSE_S1_OVERRUN] = f_over || set_over; // RULE_10
      byte1_d[`DRSE_S1_CRC] = f_crc || set_crc; // RULE_11
      byte1_d[`DRSE_S1_LATE] = f_late || set_late; // RULE_12
      byte1_d[`DRSE_S1_MISSING] = f_miss || set_miss; // RULE_13
      byte1_d[`DRSE_S1_WPROT] = f_wp || set_wp; // RULE_14
      byte1_d[`DRSE_S1_IDLOST] = f_idl || set_idl; // RULE_15
   end

   // a start in the result phase abandons the unread bytes
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (cmd_start_i) begin
               state_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (cmd_done_i) begin
               state_d = ST_RES;
            end
         end
         ST_RES: begin
            if (cmd_start_i) begin
               state_d = ST_EXEC;
            end else if (last_rd) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // bytes frozen at termination and held until the next command terminates
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         byte0_q <= `DRSE_BYTE_RESET;
         byte1_q <= `DRSE_BYTE_RESET;
      end else if (capture) begin
         byte0_q <= byte0_d; // RULE_16
         byte1_q <= byte1_d; // RULE_16
      end
   end

   // which byte the next read returns
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_idx_q <= 1'b0;
      end else if (capture) begin
         rd_idx_q <= 1'b0;
      end else if (first_rd) begin
         rd_idx_q <= 1'b1;
      end
   end

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         result_busy_o <= 1'b0;
         result_valid_o <= 1'b0;
      end else begin
         result_busy_o <= (state_d == ST_EXEC);
         result_valid_o <= (state_d == ST_RES); // RULE_01
      end
   end

   // byte 0 goes out with valid, so the host never sees a blank first byte
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         result_data_o <= `DRSE_BYTE_RESET;
      end else if (state_d != ST_RES) begin
         result_data_o <= `DRSE_BYTE_RESET;
      end else if (capture) begin
         result_data_o <= byte0_d; // RULE_01
      end else if (first_rd) begin
         result_data_o <= byte1_q; // RULE_01
      end else begin
         result_data_o <= rd_idx_q ? byte1_q : byte0_q; // RULE_16
      end
   end
endmodule // drse_encoder

// file: src/drse_defs.vh
`ifndef DRSE_DEFS_VH
`define DRSE_DEFS_VH
// termination class codes
`define DRSE_TC_NORMAL 2'h0
`define DRSE_TC_ABNORMAL 2'h1
`define DRSE_TC_INVALID 2'h2
`define DRSE_TC_POLLING 2'h3
// status byte 0 field positions
`define DRSE_S0_TC_HI 7
`define DRSE_S0_TC_LO 6
`define DRSE_S0_POS_DONE 5
`define DRSE_S0_DRV_FAULT 4
`define DRSE_S0_HEAD 2
`define DRSE_S0_DRV_HI 1
`define DRSE_S0_DRV_LO 0
// status byte 1 field positions
`define DRSE_S1_OVERRUN 7
`define DRSE_S1_CRC 5
`define DRSE_S1_LATE 4
`define DRSE_S1_MISSING 2
`define DRSE_S1_WPROT 1
`define DRSE_S1_IDLOST 0
// limits
`define DRSE_RECAL_STEPS 7'h50
`define DRSE_LAST_SECTOR 8'hFF
`define DRSE_INDEX_LIMIT 2'h2
// result byte count
`define DRSE_RESULT_BYTES 2'h2
`define DRSE_BYTE_RESET 8'h00
`endif

// file: src/drse_sticky.v
// set-dominant sticky flag, cleared at command start
module drse_sticky (
   input wire mclk_i,
   input wire reset_n_i,
   input wire clr_i,
   input wire set_i,
   output reg flag_o
);
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule // drse_sticky

// file: tb/drse_chk.sv
module drse_chk (
   input wire mclk_i,
   input wire reset_n_i,
   input wire cmd_start_i,
   input wire cmd_done_i,
   input wire cmd_invalid_i,
   input wire poll_abort_i,
   input wire side_select_value_i,
   input wire [1:0] drive_number_i,
   input wire rd_strobe_i,
   input wire [7:0] result_data_o,
   input wire result_valid_o,
   input wire result_busy_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   wire fin = result_busy_o && cmd_done_i;
   wire rd = result_valid_o && rd_strobe_i;
   logic first_q;
   // high while byte 0 is still on offer
   always @(posedge mclk_i or negedge reset_n_i)
      if (!reset_n_i) first_q <= 1'b0;
      else if (fin || rd) first_q <= fin;
   AST_FIN: assert property (fin |=> result_valid_o && !result_busy_o)
      else $error("no result phase");
   AST_INV: assert property (fin && cmd_invalid_i |=> result_data_o[7:6] == 2'h2)
      else $error("bad invalid class");
   AST_POLL: assert property (fin && !cmd_invalid_i && poll_abort_i |=> result_data_o[7:6] == 2'h3)
      else $error("bad polling class");
   AST_SEL: assert property (fin |=>
      result_data_o[2:0] == {$past(side_select_value_i), $past(drive_number_i)}) else $error("bad head or drive");
   AST_ZERO0: assert property (fin |=> !result_data_o[3])
      else $error("byte 0 unused bit set");
   AST_ZERO1: assert property (rd && first_q |=> result_data_o[6] == 1'b0 && result_data_o[3] == 1'b0)
      else $error("byte 1 unused bit set");
   AST_HOLD: assert property (result_valid_o && !rd_strobe_i && !cmd_start_i |=> $stable(result_data_o))
      else $error("result byte moved");
   AST_END: assert property (rd && !first_q |=> !result_valid_o && result_data_o == 8'h00)
      else $error("result phase not closed");
endmodule // drse_chk

// file: tb/drse_host.sv
module drse_host (
   input wire mclk_i,
   input wire result_valid_o,
   input wire [7:0] result_data_o,
   output logic rd_strobe_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial rd_strobe_i = 1'b0;
   // waits up to 16 cycles for the result phase, then reads byte 0 then byte 1 even if valid never rose
   task rd(output logic [7:0] b0, output logic [7:0] b1, output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 16 && !ok; n++) begin
         if (result_valid_o === 1'b1) ok = 1'b1;
         else @(posedge mclk_i) #1;
      end
      b0 = result_data_o;
      rd_strobe_i = 1'b1;
      @(posedge mclk_i) #1 rd_strobe_i = 1'b0;
      @(posedge mclk_i) #1 b1 = result_data_o;
      rd_strobe_i = 1'b1;
      @(posedge mclk_i) #1 rd_strobe_i = 1'b0;
   endtask
endmodule // drse_host

// file: tb/drse_encoder_test.sv
module drse_encoder_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_i = 1'b0, reset_n_i = 1'b0;
   logic [14:0] ev = 15'h0000;
   logic [7:0] ty = 8'h00, cylinder_i = 8'h05, sector_num_i = 8'hFF;
   logic [1:0] term_class_i = 2'h0, drive_number_i = 2'h0;
   logic cmd_invalid_i = 1'h0, poll_abort_i = 1'h0, step_outward_i = 1'h0;
   logic cylinder_zero_sense_i = 1'h0, side_select_value_i = 1'h0;
   wire rd_strobe_i, result_valid_o, result_busy_o;
   wire [7:0] result_data_o;
   int compares = 0, miscompares = 0;
   localparam logic [7:0] mt [12] = '{8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h20, 8'h40, 8'h18, 8'h88};
   localparam logic [12:0] me [12] = '{13'h084, 13'h014, 13'h024, 13'h044, 13'h804, 13'h000, 13'h00C, 13'h004,
      13'h100, 13'h200, 13'h006, 13'h1004};
   localparam logic [7:0] mx [12] = '{8'h04, 8'h20, 8'h20, 8'h10, 8'h01, 8'h80, 8'h80, 8'h00, 8'h04, 8'h04, 8'h01, 8'h02};
   always #4 mclk_i = ~mclk_i;
   drse_encoder u_drse_encoder (.*, .step_pulse_i(ev[0]), .index_pulse_input_i(ev[1]), .transfer_stop_i(ev[2]),
      .sector_access_i(ev[3]), .id_crc_err_i(ev[4]), .data_crc_err_i(ev[5]), .service_late_i(ev[6]),
      .sector_not_found_i(ev[7]), .id_read_fail_i(ev[8]), .seq_fail_i(ev[9]), .id_mark_found_i(ev[10]),
      .data_mark_missing_i(ev[11]), .protect_tab_input_i(ev[12]), .cmd_start_i(ev[13]), .cmd_done_i(ev[14]),
      .is_seek_cmd_i(ty[0]), .is_recal_cmd_i(ty[1]), .is_rel_seek_cmd_i(ty[2]), .is_rw_data_cmd_i(ty[3]),
      .is_read_data_cmd_i(ty[4]), .is_read_id_cmd_i(ty[5]), .is_read_track_cmd_i(ty[6]), .is_write_cmd_i(ty[7]));
   drse_host u_drse_host (.*);
   task conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] x, input logic [7:0] g);
      compares++;
      if (g !== x) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   // one-cycle pulse, a spare edge after so a repeat never re-drives in the same step
   task p(input int i);
      ev[i] = 1'b1;
      @(posedge mclk_i) #1 ev[i] = 1'b0;
      @(posedge mclk_i) #1;
   endtask
   task run(input logic [7:0] t, input logic [12:0] e, input logic [6:0] n, input logic [7:0] x0, input logic [7:0] x1);
      logic [7:0] b0, b1;
      logic ok;
      ty = t;
      p(13);
      chk("busy", 8'h01, {7'h00, result_busy_o});
      repeat (n) p(0);
      for (int i = 1; i < 13; i++) if (e[i]) repeat (i == 1 ? 2 : 1) p(i);
      p(14);
      // any error flag turns a normal ending into class 01
      if (term_class_i == 2'h0 && x0[7:6] == 2'h0 && (x0[4] || x1 != 8'h00)) x0[7:6] = 2'h1;
      x0[2:0] = {side_select_value_i, drive_number_i};
      repeat (3) @(posedge mclk_i) #1;
      u_drse_host.rd(b0, b1, ok);
      if (!ok) begin
         miscompares++;
      end
      chk("byte0", x0, b0);
      chk("byte1", x1, b1);
      chk("end_valid", 8'h00, {7'h00, result_valid_o});
   endtask
   task s_class;
      logic [1:0] c;
      for (int i = 0; i < 5; i++) begin
         term_class_i = (i == 1) ? 2'h1 : 2'h0;
         cmd_invalid_i = (i == 2 || i == 4);
         poll_abort_i = (i > 2);
         {side_select_value_i, drive_number_i} = i[2:0];
         c = (i == 3) ? 2'h3 : (i == 1) ? 2'h1 : (i > 1) ? 2'h2 : 2'h0;
         run(8'h00, 13'h0000, 7'h00, {c, 6'h00}, 8'h00);
      end
      term_class_i = 2'h0;
      cmd_invalid_i = 1'h0;
      poll_abort_i = 1'h0;
   endtask
   task s_seek;
      run(8'h01, 13'h0000, 7'h00, 8'h20, 8'h00);
      run(8'h02, 13'h0000, 7'h4F, 8'h20, 8'h00);
      run(8'h02, 13'h0000, 7'h50, 8'h30, 8'h00);
      cylinder_zero_sense_i = 1'h1;
      run(8'h02, 13'h0000, 7'h50, 8'h20, 8'h00);
      cylinder_zero_sense_i = 1'h0;
      cylinder_i = 8'h00;
      step_outward_i = 1'h1;
      run(8'h04, 13'h0000, 7'h01, 8'h30, 8'h00);
      cylinder_i = 8'h05;
      run(8'h04, 13'h0000, 7'h01, 8'h20, 8'h00);
      step_outward_i = 1'h0;
   endtask
   task s_media;
      for (int i = 0; i < 12; i++) begin
         run(mt[i], me[i], 7'h00, 8'h00, mx[i]);
      end
   endtask
   task s_refuse;
      p(14);
      chk("idle_valid", 8'h00, {7'h00, result_valid_o});
      ty = 8'h00;
      p(13);
      p(14);
      p(13);
      chk("abort_valid", 8'h00, {7'h00, result_valid_o});
      run(8'h18, 13'h0004, 7'h00, 8'h00, 8'h00);
   endtask
   initial begin
      repeat (3) @(posedge mclk_i);
      #1 reset_n_i = 1'b1;
      s_class();
      s_seek();
      s_media();
      s_refuse();
      conclude();
   end
endmodule // drse_encoder_test
bind drse_encoder drse_chk u_drse_chk (.*);
